// file: shared/idc_pkg.sv
package idc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NCH       = 4;
  localparam int NSCOPE    = 4;
  localparam int NSENSE    = 55;
  localparam int SELW      = 6;
  localparam int ADCW      = 15;
  localparam int DACW      = 8;
  localparam int BBW       = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int SCOPE_RATE_HZ = 5_000_000;
  localparam int SCOPE_DIV     = CLK_HZ / SCOPE_RATE_HZ;

  // ****************************************************************
  // Sense full-scale spans, volts and amps
  // ****************************************************************
  localparam int SOL_V_MIN = -250;
  localparam int SOL_V_MAX = 250;
  localparam int LS_I_MIN  = -12;
  localparam int LS_I_MAX  = 50;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CLAMP     = 8'h04;
  localparam logic [7:0] REG_BB_TIME   = 8'h08;
  localparam logic [7:0] REG_CMD       = 8'h0C;
  localparam logic [7:0] REG_SCOPE_SEL = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_PEAK      = 8'h20;
  localparam logic [7:0] REG_HOLD      = 8'h30;
  localparam logic [7:0] REG_PIEZO     = 8'h40;
  localparam logic [7:0] REG_SCOPE     = 8'h50;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_CLAMP_BIT = 0;
  localparam int CTRL_PUMP_BIT  = 1;
  localparam int CTRL_PIEZO_LSB = 4;
  localparam int CMD_INJ_LSB    = 0;
  localparam int CMD_HV_LSB     = 4;
  localparam int CMD_DIS_LSB    = 8;
  localparam int CMD_PUMP_BIT   = 12;
  localparam int CMD_MUX_BIT    = 13;
  localparam int THR_UP_LSB     = 0;
  localparam int THR_LO_LSB     = 8;

  localparam logic [31:0]    CTRL_RST  = 32'h0000_0000;
  localparam logic [DACW-1:0] CLAMP_RST = 8'h00;
  localparam logic [BBW-1:0] BB_RST    = 16'h0100;
  localparam logic [31:0]    CMD_RST   = 32'h0000_0000;
  localparam logic [15:0]    THR_RST   = 16'h0000;
  localparam logic [SELW-1:0] SEL_RST  = 6'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DRIVE,
    ST_BACKBOOST
  } idc_state_t;

  typedef struct packed {
    logic high_voltage_top_switch;
    logic low_voltage_top_switch;
    logic piezo_top_switch;
    logic bottom_switch;
  } idc_sw_t;

  typedef struct packed {
    logic cur_upper;
    logic cur_lower;
    logic volt_upper;
    logic volt_lower;
  } idc_cmp_t;

  typedef struct packed {
    logic [DACW-1:0] cur_upper;
    logic [DACW-1:0] cur_lower;
    logic [DACW-1:0] volt_upper;
    logic [DACW-1:0] volt_lower;
  } idc_dac_t;

endpackage

// file: verilog/idc_bank.sv
`timescale 1ns/100ps
// What this block does
// - Solenoid lowside held off for backboost time after injection
// - Per-bank backboost mode: bypass or clamp stage
// - One clamp setting per bank, shared by channels
// - Four scope channels, 55 selectable signals
// - Solenoid voltage samples span -250 to +250 V
// - Lowside current samples span -12 to +50 A
// - Current DACs follow active profile phase
// - Upper current trip turns highside off
// - Lower current trip turns highside on
// - Piezo voltage DACs follow charge profile
// - Upper voltage trip disables piezo current control
// - Lower voltage trip re-enables piezo current control
// - Piezo current loop nested inside voltage loop
// - Switches only fully on or off
// - Lowside stays on while highside freewheels
// - Extra lowside channel for pump or multiplexing
// - Piezo or solenoid highside path by load
// - Solenoid lowside on through current control
// - Idle lowside on only if relay on, unlocked
// - Low-voltage highside never used for piezo
// - Piezo discharge cycles lowside by current profile
module idc_bank
  import idc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire idc_cmp_t [NCH-1:0]     cmp_in,
  input  wire logic                   main_relay_on,
  input  wire logic                   outputs_locked,
  output idc_sw_t [NCH-1:0]           sw,
  output logic                        pump_bottom_switch,
  output idc_dac_t [NCH-1:0]          dac,
  output logic                        clamp_mode,
  output logic [DACW-1:0]             clamp_level,
  output logic [NSCOPE*SELW-1:0]      scope_sel,
  output logic                        scope_convert,
  input  wire logic [NSCOPE*ADCW-1:0] scope_data
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [NCH*4+1:0] sync_a;
  logic [NCH*4+1:0] sync_b;
  idc_cmp_t [NCH-1:0] cmp;
  logic              relay_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {main_relay_on, outputs_locked, cmp_in};
      sync_b <= sync_a;
    end
  end
  assign cmp      = sync_b[NCH*4-1:0];
  assign relay_ok = sync_b[NCH*4+1] & ~sync_b[NCH*4];

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [31:0]       ctrl;
  logic [DACW-1:0]   clamp;
  logic [BBW-1:0]    bb_time;
  logic [31:0]       cmd;
  logic [SELW-1:0]   sel [NSCOPE];
  logic [15:0]       peak [NCH];
  logic [15:0]       hold [NCH];
  logic [15:0]       pz [NCH];
  logic [ADCW-1:0]   sample [NSCOPE];
  logic              ack;
  logic [31:0]       next_rdata;
  logic [31:0]       be_mask;
  logic [31:0]       status;

  wire req      = avs_read | avs_write;
  // A write lands at the edge at which the master sees waitrequest low.
  wire wr_go    = avs_write & ack;
  wire [3:0] ix = {2'b00, avs_address[3:2]};
  wire in_peak  = avs_address[7:4] == REG_PEAK[7:4];
  wire in_hold  = avs_address[7:4] == REG_HOLD[7:4];
  wire in_pz    = avs_address[7:4] == REG_PIEZO[7:4];
  wire in_scope = avs_address[7:4] == REG_SCOPE[7:4];
  wire [1:0] ci = ix[1:0];

  assign avs_waitrequest = req & ~ack;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  wire [31:0] w_ctrl  = merge(ctrl, avs_writedata, be_mask);
  wire [31:0] w_cmd   = merge(cmd, avs_writedata, be_mask);
  wire [31:0] w_clamp = merge({24'h0, clamp}, avs_writedata, be_mask);
  wire [31:0] w_bb    = merge({16'h0, bb_time}, avs_writedata, be_mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RST;
      clamp   <= CLAMP_RST;
      bb_time <= BB_RST;
      cmd     <= CMD_RST;
    end else if (wr_go) begin
      if (avs_address == REG_CTRL)    ctrl    <= w_ctrl;
      if (avs_address == REG_CLAMP)   clamp   <= w_clamp[DACW-1:0];
      if (avs_address == REG_BB_TIME) bb_time <= w_bb[BBW-1:0];
      if (avs_address == REG_CMD)     cmd     <= w_cmd;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (avs_address == REG_CTRL) begin
      next_rdata = ctrl;
    end else if (avs_address == REG_CLAMP) begin
      next_rdata = {24'h0, clamp};
    end else if (avs_address == REG_BB_TIME) begin
      next_rdata = {16'h0, bb_time};
    end else if (avs_address == REG_CMD) begin
      next_rdata = cmd;
    end else if (avs_address == REG_SCOPE_SEL) begin
      next_rdata = {2'b0, sel[3], 2'b0, sel[2], 2'b0, sel[1], 2'b0, sel[0]};
    end else if (avs_address == REG_STATUS) begin
      next_rdata = status;
    end else if (in_peak && ix < 4'(NCH)) begin
      next_rdata = {16'h0, peak[ci]};
    end else if (in_hold && ix < 4'(NCH)) begin
      next_rdata = {16'h0, hold[ci]};
    end else if (in_pz && ix < 4'(NCH)) begin
      next_rdata = {16'h0, pz[ci]};
    end else if (in_scope && ix < 4'(NSCOPE)) begin
      next_rdata = {{(32-ADCW){sample[ci][ADCW-1]}}, sample[ci]};
    end
  end

  // ****************************************************************
  // Bank-wide backboost clamp
  // ****************************************************************
  // backboost mode select
  assign clamp_mode  = ctrl[CTRL_CLAMP_BIT];
  assign clamp_level = clamp;

  // ****************************************************************
  // Scope channels
  // ****************************************************************
  logic [2:0] div;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div           <= 3'h0;
      scope_convert <= 1'b0;
    end else begin
      div           <= (div == 3'(SCOPE_DIV - 1)) ? 3'h0 : div + 3'h1;
      scope_convert <= div == 3'(SCOPE_DIV - 1);
    end
  end

  // The sample taken with a strobe is the one converted at the previous
  // strobe, so a new select shows up one sample period late.
  // per-scope select and capture
  for (genvar k = 0; k < NSCOPE; k++) begin : g_scope
    wire sel_hit = wr_go && avs_address == REG_SCOPE_SEL
                   && avs_byteenable[k];
    wire [SELW-1:0] sel_new = avs_writedata[k*8 +: SELW];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sel[k] <= SEL_RST;
      end else if (sel_hit && sel_new < SELW'(NSENSE)) begin
        sel[k] <= sel_new;
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sample[k] <= '0;
      end else if (scope_convert) begin
        sample[k] <= scope_data[k*ADCW +: ADCW];
      end
    end
    assign scope_sel[k*SELW +: SELW] = sel[k];
  end

  // ****************************************************************
  // Driver channels
  // ****************************************************************
  idc_state_t     st [NCH];
  logic [NCH-1:0] hs_on;
  logic [NCH-1:0] volt_en;
  logic [NCH-1:0] in_bb;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire inj   = cmd[CMD_INJ_LSB + c];
    wire hv    = cmd[CMD_HV_LSB + c];
    wire dis   = cmd[CMD_DIS_LSB + c];
    wire piezo = ctrl[CTRL_PIEZO_LSB + c];
    wire [THR_UP_LSB+31:0] pwr = merge({16'h0, peak[c]}, avs_writedata,
                                       be_mask);
    wire [31:0] hwr = merge({16'h0, hold[c]}, avs_writedata, be_mask);
    wire [31:0] zwr = merge({16'h0, pz[c]}, avs_writedata, be_mask);
    wire [15:0] thr = hv ? peak[c] : hold[c];
    logic [BBW-1:0] cnt;
    idc_state_t     next_st;
    idc_sw_t        next_sw;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        peak[c] <= THR_RST;
        hold[c] <= THR_RST;
        pz[c]   <= THR_RST;
      end else if (wr_go && ci == 2'(c) && ix < 4'(NCH)) begin
        if (in_peak) peak[c] <= pwr[15:0];
        if (in_hold) hold[c] <= hwr[15:0];
        if (in_pz)   pz[c]   <= zwr[15:0];
      end
    end

    assign dac[c].cur_upper  = thr[THR_UP_LSB +: DACW];
    assign dac[c].cur_lower  = thr[THR_LO_LSB +: DACW];
    assign dac[c].volt_upper = pz[c][THR_UP_LSB +: DACW];
    assign dac[c].volt_lower = pz[c][THR_LO_LSB +: DACW];

    always_comb begin
      next_st = st[c];
      unique case (st[c])
        ST_IDLE:      if (inj) next_st = ST_DRIVE;
        ST_DRIVE:     if (!inj) next_st = (!piezo && bb_time != '0)
                                          ? ST_BACKBOOST : ST_IDLE;
        ST_BACKBOOST: if (cnt <= 16'h0001) next_st = ST_IDLE;
      endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        st[c] <= ST_IDLE;
        cnt   <= '0;
      end else begin
        st[c] <= next_st;
        cnt   <= (st[c] == ST_DRIVE) ? bb_time : cnt - BBW'(cnt != '0);
      end
    end

    // A lower trip wins over an upper one, so a noisy comparator pair
    // errs toward keeping current up rather than collapsing it.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hs_on[c]   <= 1'b1;
        volt_en[c] <= 1'b1;
      end else if (st[c] != ST_DRIVE) begin
        hs_on[c]   <= 1'b1;
        volt_en[c] <= 1'b1;
      end else begin
        if (cmp[c].cur_lower) hs_on[c] <= 1'b1;
        else if (cmp[c].cur_upper) hs_on[c] <= 1'b0;
        if (cmp[c].volt_lower) volt_en[c] <= 1'b1;
        else if (cmp[c].volt_upper) volt_en[c] <= 1'b0;
      end
    end

    wire charge = hs_on[c] & (~piezo | volt_en[c]) & ~(piezo & dis);

    always_comb begin
      next_sw = '0;
      if (relay_ok) begin
        unique case (st[c])
          ST_IDLE:      next_sw.bottom_switch = 1'b1;
          ST_BACKBOOST: next_sw.bottom_switch = 1'b0;
          ST_DRIVE: begin
            next_sw.high_voltage_top_switch = charge & hv & ~piezo;
            next_sw.low_voltage_top_switch  = charge & ~hv & ~piezo;
            next_sw.piezo_top_switch        = charge & piezo;
            next_sw.bottom_switch = (piezo & dis) ? hs_on[c] : 1'b1;
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sw[c] <= '0;
      end else begin
        sw[c] <= next_sw;
      end
    end

    assign in_bb[c] = st[c] == ST_BACKBOOST;

    property p_bb_low_off;
      in_bb[c] |=> !sw[c].bottom_switch;
    endproperty
    a_bb_low_off: assert property (p_bb_low_off)
      else $error("lowside on during backboost");

    property p_bb_enter;
      (st[c] == ST_DRIVE && !inj && !piezo && bb_time != '0)
        |=> in_bb[c] ##1 !sw[c].bottom_switch;
    endproperty
    a_bb_enter: assert property (p_bb_enter)
      else $error("backboost not entered at end of event");

    property p_hs_off;
      (st[c] == ST_DRIVE && cmp[c].cur_upper && !cmp[c].cur_lower)
        |=> !hs_on[c];
    endproperty
    a_hs_off: assert property (p_hs_off)
      else $error("highside not released on upper trip");

    property p_hs_on;
      (st[c] == ST_DRIVE && cmp[c].cur_lower) |=> hs_on[c];
    endproperty
    a_hs_on: assert property (p_hs_on)
      else $error("highside not restored on lower trip");

    property p_v_off;
      (st[c] == ST_DRIVE && cmp[c].volt_upper && !cmp[c].volt_lower
       && piezo && relay_ok && $stable(ctrl))
        |=> ##1 !sw[c].piezo_top_switch;
    endproperty
    a_v_off: assert property (p_v_off)
      else $error("piezo drive not cut on upper voltage");

    property p_v_on;
      (st[c] == ST_DRIVE && cmp[c].volt_lower) |=> volt_en[c];
    endproperty
    a_v_on: assert property (p_v_on)
      else $error("piezo current control not re-enabled");

    property p_no_lv_piezo;
      sw[c].low_voltage_top_switch |-> !$past(piezo);
    endproperty
    a_no_lv_piezo: assert property (p_no_lv_piezo)
      else $error("low-voltage highside used in piezo mode");

    property p_relay_off;
      !relay_ok |=> (sw[c] == '0);
    endproperty
    a_relay_off: assert property (p_relay_off)
      else $error("switch on with relay off or outputs locked");

    property p_sol_low;
      (st[c] == ST_DRIVE && !piezo && relay_ok) |=> sw[c].bottom_switch;
    endproperty
    a_sol_low: assert property (p_sol_low)
      else $error("solenoid lowside dropped during drive");
  end

  // ****************************************************************
  // Pump channel and status
  // ****************************************************************
  // pump or multiplex source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_bottom_switch <= 1'b0;
    end else begin
      pump_bottom_switch <= relay_ok & (ctrl[CTRL_PUMP_BIT]
                            ? cmd[CMD_PUMP_BIT] : cmd[CMD_MUX_BIT]);
    end
  end

  assign status = {19'h0, relay_ok, volt_en, hs_on, in_bb};

  property p_bus_answer;
    req |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in two cycles");

endmodule

// file: bench/idc_power_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Power stage model
// ****************************************************************
module idc_power_model
  import idc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire idc_sw_t [NCH-1:0]      sw,
  input  wire idc_dac_t [NCH-1:0]     dac,
  input  wire logic [NSCOPE*SELW-1:0] scope_sel,
  output idc_cmp_t [NCH-1:0]          cmp_in,
  output logic [NSCOPE*ADCW-1:0]      scope_data
);
  int cur [NCH];
  int volt [NCH];

  // Current rises fast under a top switch and slowly freewheels down.
  // With the bottom switch open the current collapses at once.
  always @(posedge clk or negedge rst_n) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rst_n) begin
        cur[c]  <= 0;
        volt[c] <= 0;
      end else if (!sw[c].bottom_switch) begin
        cur[c] <= 0;
      end else if (sw[c][3] | sw[c][2] | sw[c][1]) begin
        cur[c] <= (cur[c] > 250) ? 254 : cur[c] + 4;
        if (sw[c].piezo_top_switch && volt[c] < 250) begin
          volt[c] <= volt[c] + 1;
        end
      end else if (cur[c] > 0) begin
        cur[c] <= cur[c] - 1;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cmp_in[c].cur_upper  = cur[c] > int'(dac[c].cur_upper);
      cmp_in[c].cur_lower  = cur[c] < int'(dac[c].cur_lower);
      cmp_in[c].volt_upper = volt[c] > int'(dac[c].volt_upper);
      cmp_in[c].volt_lower = volt[c] < int'(dac[c].volt_lower);
    end
  end

  // Each scope returns a negative code that names its own selection.
  always_comb begin
    for (int k = 0; k < NSCOPE; k++) begin
      scope_data[k*ADCW +: ADCW] =
        {1'b1, 6'h00, 2'(k), scope_sel[k*SELW +: SELW]};
    end
  end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/100ps
// ****************************************************************
// Bank bench
// ****************************************************************
module tb_top;
  import idc_pkg::*;
  logic                   clk;
  logic                   rst_n;
  logic [7:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  idc_cmp_t [NCH-1:0]     cmp_in;
  logic                   main_relay_on;
  logic                   outputs_locked;
  idc_sw_t [NCH-1:0]      sw;
  logic                   pump_bottom_switch;
  idc_dac_t [NCH-1:0]     dac;
  logic                   clamp_mode;
  logic [DACW-1:0]        clamp_level;
  logic [NSCOPE*SELW-1:0] scope_sel;
  logic                   scope_convert;
  logic [NSCOPE*ADCW-1:0] scope_data;
  logic [31:0]            rd;
  logic [5:0]             sv [NSCOPE];
  int                     fail_count;
  int                     checks;
  int                     cyc = 0;
  int                     n_hv, n_lv, n_pz, n_off, n_rise;

  idc_bank idc_bank_inst (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in),
    .main_relay_on(main_relay_on), .outputs_locked(outputs_locked),
    .sw(sw), .pump_bottom_switch(pump_bottom_switch), .dac(dac),
    .clamp_mode(clamp_mode), .clamp_level(clamp_level),
    .scope_sel(scope_sel), .scope_convert(scope_convert),
    .scope_data(scope_data));

  idc_power_model idc_power_model_inst (.clk(clk), .rst_n(rst_n),
    .sw(sw), .dac(dac), .scope_sel(scope_sel), .cmp_in(cmp_in),
    .scope_data(scope_data));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic wrap_up;
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The request stands until the edge at which waitrequest is seen low.
  // Returning on the falling edge lets the landed write settle first.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic watch(input int c, input int n);
    logic top;
    logic last;
    {n_hv, n_lv, n_pz, n_off, n_rise} = '0;
    last = 1'b0;
    repeat (n) begin
      @(negedge clk);
      top = sw[c][3] | sw[c][2] | sw[c][1];
      n_hv += int'(sw[c].high_voltage_top_switch === 1'b1);
      n_lv += int'(sw[c].low_voltage_top_switch === 1'b1);
      n_pz += int'(sw[c].piezo_top_switch === 1'b1);
      n_off += int'(sw[c].bottom_switch !== 1'b1);
      if (top === 1'b1 && !last) n_rise++;
      last = (top === 1'b1);
    end
  endtask

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {rst_n, main_relay_on, outputs_locked} = 3'b000;
    fail_count = 0;
    checks = 0;
    sv = '{6'd7, 6'd20, 6'd3, 6'd54};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    idle(4);
    chk("bot_relay_off", sw[0].bottom_switch, 1'b0);
    rchk("bb_time_rst", REG_BB_TIME, 32'(BB_RST));
    rchk("ctrl_rst", REG_CTRL, CTRL_RST);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h18, 32'h0);
    @(posedge clk) main_relay_on <= 1'b1;
    idle(5);
    chk("idle_bot", sw[3].bottom_switch, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("relay_ok", rd[12], 1'b1);
    @(posedge clk) outputs_locked <= 1'b1;
    idle(5);
    chk("locked_bot", sw[2].bottom_switch, 1'b0);
    @(posedge clk) outputs_locked <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_CLAMP, 32'hA5);
    chk("clamp_on", clamp_mode, 1'b1);
    chk("clamp_lvl", clamp_level, 8'hA5);
    bus(1'b1, REG_CTRL, 32'h0);
    chk("clamp_off", clamp_mode, 1'b0);
    bus(1'b1, REG_HOLD, 32'h3C64);
    bus(1'b1, REG_PEAK, 32'hA0C8);
    bus(1'b1, REG_BB_TIME, 32'h14);
    bus(1'b1, REG_CMD, 32'h11);
    watch(0, 300);
    chk("peak_up", dac[0].cur_upper, 8'hC8);
    chk("peak_lo", dac[0].cur_lower, 8'hA0);
    chk("hv_cycles", 32'(n_rise > 2), 32'h1);
    chk("hv_no_lv", n_lv, 32'h0);
    chk("hv_no_pz", n_pz, 32'h0);
    chk("hv_bot", n_off, 32'h0);
    bus(1'b1, REG_CMD, 32'h1);
    idle(6);
    watch(0, 400);
    chk("hold_up", dac[0].cur_upper, 8'h64);
    chk("lv_cycles", 32'(n_rise > 2), 32'h1);
    chk("lv_no_hv", n_hv, 32'h0);
    chk("lv_bot", n_off, 32'h0);
    // Clearing the inject bit opens the bottom switch for the count.
    bus(1'b1, REG_CMD, 32'h0);
    watch(0, 60);
    chk("bb_len", n_off, 32'd20);
    chk("bb_idle", sw[0].bottom_switch, 1'b1);
    bus(1'b1, REG_BB_TIME, 32'h0);
    bus(1'b1, REG_CMD, 32'h11);
    idle(20);
    bus(1'b1, REG_CMD, 32'h0);
    watch(0, 30);
    chk("bb_zero", n_off, 32'h0);
    bus(1'b1, REG_CTRL, 32'h20);
    bus(1'b1, REG_HOLD + 8'h04, 32'h3C64);
    bus(1'b1, REG_PIEZO + 8'h04, 32'h0028);
    bus(1'b1, REG_CMD, 32'h2);
    watch(1, 300);
    chk("pz_vup", dac[1].volt_upper, 8'h28);
    chk("pz_used", 32'(n_pz > 0), 32'h1);
    chk("pz_no_top", n_hv + n_lv, 32'h0);
    chk("pz_stop", sw[1].piezo_top_switch, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("pz_ven_off", rd[9], 1'b0);
    bus(1'b1, REG_PIEZO + 8'h04, 32'hC828);
    watch(1, 100);
    chk("pz_resume", 32'(n_pz > 0), 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("pz_ven_on", rd[9], 1'b1);
    // Zero thresholds trip the upper comparator and park the loop off.
    bus(1'b1, REG_HOLD + 8'h04, 32'h0000);
    bus(1'b1, REG_CMD, 32'h202);
    idle(6);
    watch(1, 100);
    chk("dis_tops", n_pz + n_hv + n_lv, 32'h0);
    chk("dis_low", 32'(n_off > 0), 32'h1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG_CTRL, i ? 32'h2 : 32'h0);
      bus(1'b1, REG_CMD, i ? 32'h1000 : 32'h2000);
      idle(4);
      chk("pump_on", pump_bottom_switch, 1'b1);
    end
    bus(1'b1, REG_CMD, 32'h0);
    idle(4);
    chk("pump_off", pump_bottom_switch, 1'b0);
    bus(1'b1, REG_SCOPE_SEL, 32'h3603_1407);
    bus(1'b1, REG_SCOPE_SEL, 32'h3603_1437);
    chk("scope_sel", scope_sel, {8'h0, sv[3], sv[2], sv[1], sv[0]});
    idle(12);
    for (int k = 0; k < NSCOPE; k++) begin
      rchk("sample", REG_SCOPE + 8'(4 * k),
           {18'h3FFFF, 6'h00, 2'(k), sv[k]});
    end
    n_rise = 0;
    repeat (50) begin
      @(negedge clk);
      n_rise += int'(scope_convert === 1'b1);
    end
    chk("convert_rate", n_rise, 32'd10);
    @(posedge clk) main_relay_on <= 1'b0;
    idle(5);
    chk("relay_drop", sw[1].bottom_switch, 1'b0);
    wrap_up();
  end
endmodule
